// [cycle_phase_divider.sv]
// Divider that marks the first phase of each instruction cycle
`timescale 1ns/1ps
`default_nettype none
module cycle_phase_divider #(
  parameter int PHASE_COUNT = stack_exec_pkg::PHASES
) (
  input wire logic ref_clk,
  input wire logic rst,
  output logic cycle_tick,
  output logic [1:0] phase
);
  typedef struct packed {
    logic [1:0] count;
    logic tick;
  } div_state_t;

  div_state_t cur;
  div_state_t next_cur;

  // Count phases, pulse on the wrap
  always_comb begin
    next_cur = cur;
    next_cur.tick = 1'b0;
    if (cur.count == 2'(PHASE_COUNT - 1)) begin
      next_cur.count = 2'h0;
      next_cur.tick = 1'b1;
    end else begin
      next_cur.count = cur.count + 2'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign cycle_tick = cur.tick;
  assign phase = cur.count;
endmodule
`default_nettype wire

// [data_memory_model.sv]
// Behavioural data memory on the far side of the request port
`timescale 1ns/1ps
`default_nettype none
module data_memory_model (
  input wire logic ref_clk,
  input wire stack_exec_pkg::mem_req_t mem_req,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [4096];
  int writes;
  // Distinct contents so a wrong source address shows
  initial begin
    mem_rdata = 8'h00;
    for (int i = 0; i < 4096; i++) mem[i] = 8'(i) ^ 8'h5A;
  end
  // Read data is only good the clock after the strobe; it toggles otherwise
  always @(posedge ref_clk) begin
    mem_rdata <= mem_req.rd_en ? mem[mem_req.addr] : ~mem_rdata;
    if (mem_req.wr_en) begin
      mem[mem_req.addr] <= mem_req.wdata;
      writes <= writes + 1;
    end
  end
endmodule
`default_nettype wire

// [indexed_stack_instruction_exec.sv]
// Decode and execute of the stack-oriented extended instructions
//
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module indexed_stack_instruction_exec #(
  parameter int PHASE_COUNT = stack_exec_pkg::PHASES
) (
  input wire logic ref_clk,
  input wire logic rst,
  // Instruction words from fetch
  input wire logic instr_valid,
  input wire logic [stack_exec_pkg::WORD_W-1:0] instr_word,
  output logic instr_ready,
  output logic cycle_tick,
  // Data memory
  output stack_exec_pkg::mem_req_t mem_req,
  input wire logic [stack_exec_pkg::DATA_W-1:0] mem_rdata,
  // Return path
  input wire logic [stack_exec_pkg::PC_W-1:0] return_stack_top,
  output logic pc_load,
  output logic [stack_exec_pkg::PC_W-1:0] pc_load_value,
  // Standard operand resolution
  input wire stack_exec_pkg::operand_t std_operand,
  output logic [stack_exec_pkg::ADDR_W-1:0] std_addr,
  output logic std_dest_is_file,
  output logic std_indexed,
  output stack_exec_pkg::ptr_set_t pointers,
  output logic ext_enabled,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  typedef struct packed {
    stack_exec_pkg::state_t state;
    stack_exec_pkg::ptr_set_t ptr;
    logic ext_en;
    stack_exec_pkg::mem_req_t mem;
    logic capture;
    logic [stack_exec_pkg::DATA_W-1:0] moved;
    logic pc_load;
    logic [stack_exec_pkg::PC_W-1:0] pc_value;
    stack_exec_pkg::opkind_t last_op;
    logic last_skipped;
    logic [31:0] rdata;
    logic [stack_exec_pkg::ADDR_W-1:0] std_addr;
    logic std_dest;
    logic std_indexed;
  } exec_state_t;

  exec_state_t cur;
  exec_state_t next_cur;

  logic tick;
  logic [1:0] phase;
  logic [stack_exec_pkg::ADDR_W-1:0] res_addr;
  logic res_dest;
  logic res_indexed;
  logic take;
  logic setup;
  logic access;
  logic mapped;
  logic [stack_exec_pkg::ADDR_W-1:0] src_addr;
  logic [stack_exec_pkg::ADDR_W-1:0] dst_addr;
  logic [7:0] op_hi;
  logic [1:0] sel;
  logic [5:0] lit6;

  // One tick per instruction cycle of four phases
  cycle_phase_divider #(
    .PHASE_COUNT(PHASE_COUNT)
  ) u_div (
    .ref_clk(ref_clk),
    .rst(rst),
    .cycle_tick(tick),
    .phase(phase)
  );

  // indexed operand mode follows the extension enable
  operand_resolver u_res (
    .ext_en(cur.ext_en),
    .op(std_operand),
    .fp(cur.ptr.fp),
    .addr(res_addr),
    .dest_is_file(res_dest),
    .indexed(res_indexed)
  );

  // Instruction fields
  assign op_hi = instr_word[15:8];
  assign sel = instr_word[7:6];
  assign lit6 = instr_word[5:0];

  // both move addresses are frame-relative, sums wrap
  assign src_addr = stack_exec_pkg::fp_offset(cur.ptr.fp, {1'b0, instr_word[6:0]});
  assign dst_addr = stack_exec_pkg::fp_offset(cur.ptr.fp, {1'b0, instr_word[6:0]});

  // Fetch sees ready except in the idle return cycle
  assign instr_ready = (cur.state != stack_exec_pkg::ST_RETURN_IDLE);
  assign take = tick && instr_valid && instr_ready;

  // Bus phases and decode of the register map
  assign setup = psel && !penable;
  assign access = psel && penable;
  always_comb begin
    case (paddr)
      stack_exec_pkg::REG_CTRL,
      stack_exec_pkg::REG_FRAME,
      stack_exec_pkg::REG_PTR0,
      stack_exec_pkg::REG_PTR1,
      stack_exec_pkg::REG_STATUS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Execution, register file and output registers
  always_comb begin
    next_cur = cur;
    next_cur.mem.rd_en = 1'b0;
    next_cur.mem.wr_en = 1'b0;
    // Capture trails the read strobe, so the memory's data has a full clock
    next_cur.capture = cur.mem.rd_en;
    next_cur.pc_load = 1'b0;
    next_cur.std_addr = res_addr;
    next_cur.std_dest = res_dest;
    next_cur.std_indexed = res_indexed;

    // Read data one clock after the read strobe
    if (cur.capture) begin
      if (stack_exec_pkg::is_indirect(cur.mem.addr)) begin
        next_cur.moved = stack_exec_pkg::ZERO_DATA;
      end else begin
        next_cur.moved = mem_rdata;
      end
    end

    if (tick) begin
      case (cur.state)
        stack_exec_pkg::ST_FETCH: begin
          if (instr_valid) begin
            next_cur.last_skipped = 1'b0;
            if (!cur.ext_en) begin
              // extension off leaves these words to the core
              next_cur.last_op = stack_exec_pkg::OPK_NONE;
            end else if (instr_word[15:7] == stack_exec_pkg::OP_MOVE_FIRST) begin
              next_cur.mem.rd_en = 1'b1;
              next_cur.mem.addr = src_addr;
              next_cur.state = stack_exec_pkg::ST_MOVE_DEST;
              next_cur.last_op = stack_exec_pkg::OPK_MOVE;
            end else if (op_hi == stack_exec_pkg::OP_PUSH) begin
              // literal stored at the frame pointer
              next_cur.mem.wr_en = 1'b1;
              next_cur.mem.addr = cur.ptr.fp;
              next_cur.mem.wdata = instr_word[7:0];
              // pointer steps down after the store
              next_cur.ptr.fp = cur.ptr.fp - stack_exec_pkg::PTR_STEP;
              next_cur.last_op = stack_exec_pkg::OPK_PUSH;
            end else if (op_hi == stack_exec_pkg::OP_SUB_PTR) begin
              // select three is the returning form
              if (sel == stack_exec_pkg::SEL_RETURN) begin
                // subtract from frame pointer, then return
                next_cur.ptr.fp = cur.ptr.fp - {6'h00, lit6};
                next_cur.pc_load = 1'b1;
                next_cur.pc_value = return_stack_top;
                next_cur.state = stack_exec_pkg::ST_RETURN_IDLE;
                next_cur.last_op = stack_exec_pkg::OPK_RETURN;
              end else begin
                case (sel)
                  stack_exec_pkg::SEL_PTR0: next_cur.ptr.p0 = cur.ptr.p0 - {6'h00, lit6};
                  stack_exec_pkg::SEL_PTR1: next_cur.ptr.p1 = cur.ptr.p1 - {6'h00, lit6};
                  default: next_cur.ptr.fp = cur.ptr.fp - {6'h00, lit6};
                endcase
                next_cur.last_op = stack_exec_pkg::OPK_SUB;
              end
            end else if (instr_word[15:12] == stack_exec_pkg::OP_MOVE_SECOND) begin
              next_cur.last_op = stack_exec_pkg::OPK_NOP;
            end else begin
              next_cur.last_op = stack_exec_pkg::OPK_NONE;
            end
          end
        end
        stack_exec_pkg::ST_MOVE_DEST: begin
          if (instr_valid) begin
            next_cur.state = stack_exec_pkg::ST_FETCH;
            // protected targets and indirect targets are skipped
            if (stack_exec_pkg::is_protected(dst_addr) || stack_exec_pkg::is_indirect(dst_addr)) begin
              next_cur.last_skipped = 1'b1;
            end else begin
              next_cur.mem.wr_en = 1'b1;
              next_cur.mem.addr = dst_addr;
              next_cur.mem.wdata = cur.moved;
            end
          end
        end
        stack_exec_pkg::ST_RETURN_IDLE: begin
          // second cycle idles while the new word is fetched
          next_cur.state = stack_exec_pkg::ST_FETCH;
        end
        default: begin
          next_cur.state = stack_exec_pkg::ST_FETCH;
        end
      endcase
    end

    // Read data latched in setup so the access phase sees a register
    if (setup) begin
      case (paddr)
        stack_exec_pkg::REG_CTRL: next_cur.rdata = {31'h00000000, cur.ext_en};
        stack_exec_pkg::REG_FRAME: next_cur.rdata = {20'h00000, cur.ptr.fp};
        stack_exec_pkg::REG_PTR0: next_cur.rdata = {20'h00000, cur.ptr.p0};
        stack_exec_pkg::REG_PTR1: next_cur.rdata = {20'h00000, cur.ptr.p1};
        stack_exec_pkg::REG_STATUS: next_cur.rdata = {24'h000000, cur.last_skipped,
                                                      cur.last_op, 1'b0, 2'(cur.state), 1'b0};
        default: next_cur.rdata = 32'h00000000;
      endcase
    end

    // Software writes win over same-cycle pointer updates
    if (access && pwrite && mapped) begin
      case (paddr)
        stack_exec_pkg::REG_CTRL: begin
          if (pstrb[0]) begin
            next_cur.ext_en = pwdata[stack_exec_pkg::CTRL_EXT_BIT];
          end
        end
        stack_exec_pkg::REG_FRAME: next_cur.ptr.fp = merge(cur.ptr.fp);
        stack_exec_pkg::REG_PTR0: next_cur.ptr.p0 = merge(cur.ptr.p0);
        stack_exec_pkg::REG_PTR1: next_cur.ptr.p1 = merge(cur.ptr.p1);
        default: next_cur.ext_en = cur.ext_en;
      endcase
    end
  end

  // Byte-lane merge of a pointer write
  function automatic logic [stack_exec_pkg::ADDR_W-1:0] merge(input logic [stack_exec_pkg::ADDR_W-1:0] old);
    logic [stack_exec_pkg::ADDR_W-1:0] v;
    v = old;
    if (pstrb[0]) begin
      v[7:0] = pwdata[7:0];
    end
    if (pstrb[1]) begin
      v[11:8] = pwdata[11:8];
    end
    merge = v;
  endfunction

  // enable comes out of reset cleared
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cur <= '0;
      cur.state <= stack_exec_pkg::ST_FETCH;
      cur.ext_en <= stack_exec_pkg::CTRL_EXT_RESET;
      cur.ptr <= {stack_exec_pkg::PTR_RESET, stack_exec_pkg::PTR_RESET, stack_exec_pkg::PTR_RESET};
      cur.last_op <= stack_exec_pkg::OPK_NONE;
    end else begin
      cur <= next_cur;
    end
  end

  // Outputs
  assign cycle_tick = tick;
  assign mem_req = cur.mem;
  assign pc_load = cur.pc_load;
  assign pc_load_value = cur.pc_value;
  assign std_addr = cur.std_addr;
  assign std_dest_is_file = cur.std_dest;
  assign std_indexed = cur.std_indexed;
  assign pointers = cur.ptr;
  assign ext_enabled = cur.ext_en;
  assign prdata = cur.rdata;
  assign pready = 1'b1;
  assign pslverr = access && !mapped;
endmodule
`default_nettype wire

// [operand_resolver.sv]
// Resolves the file operand of standard byte and bit instructions
`timescale 1ns/1ps
`default_nettype none
module operand_resolver (
  input wire logic ext_en,
  input wire stack_exec_pkg::operand_t op,
  input wire logic [stack_exec_pkg::ADDR_W-1:0] fp,
  output logic [stack_exec_pkg::ADDR_W-1:0] addr,
  output logic dest_is_file,
  output logic indexed
);
  // Pick banked, frame-relative or access bank address
  always_comb begin
    indexed = 1'b0;
    if (op.a_bit) begin
      addr = {op.bank, op.f};
    end else if (ext_en && op.f <= stack_exec_pkg::ACCESS_LIMIT) begin
      // frame-relative operand, zero pointer is legacy
      addr = stack_exec_pkg::fp_offset(fp, op.f);
      indexed = 1'b1;
    end else if (op.f <= stack_exec_pkg::ACCESS_LIMIT) begin
      addr = {stack_exec_pkg::ACCESS_LOW_BANK, op.f};
    end else begin
      addr = {stack_exec_pkg::ACCESS_HIGH_BANK, op.f};
    end
  end

  assign dest_is_file = op.d_bit;
endmodule
`default_nettype wire

// [stack_exec_monitor.sv]
// Checker of the stack instruction block, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module stack_exec_monitor (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic instr_ready,
  input wire logic cycle_tick,
  input wire stack_exec_pkg::mem_req_t mem_req,
  input wire logic [20:0] return_stack_top,
  input wire logic pc_load,
  input wire logic [20:0] pc_load_value,
  input wire stack_exec_pkg::operand_t std_operand,
  input wire logic [11:0] std_addr,
  input wire logic std_indexed,
  input wire stack_exec_pkg::ptr_set_t pointers,
  input wire logic ext_enabled
);
  logic take, move_wait, move_go, push_go, sub_go;
  logic [11:0] k;
  // Accepted words; the second move word is data, not an opcode
  assign take = cycle_tick && instr_valid && instr_ready && ext_enabled;
  assign move_go = take && !move_wait && instr_word[15:7] == 9'h1D7;
  assign push_go = take && !move_wait && instr_word[15:8] == 8'hFA;
  assign sub_go = take && !move_wait && instr_word[15:8] == 8'hE9;
  assign k = {6'h00, instr_word[5:0]};
  // Tracks a pending second move word
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      move_wait <= 1'b0;
    end else if (take) begin
      move_wait <= move_go;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  chk_move_read: assert property (move_go |=> mem_req.rd_en
    && mem_req.addr == $past(pointers.fp) + {5'h00, $past(instr_word[6:0])}) else $error("move read wrong");
  chk_push_write: assert property (push_go |=> mem_req.wr_en
    && mem_req.addr == $past(pointers.fp) && mem_req.wdata == $past(instr_word[7:0])) else $error("push wrong");
  chk_push_step: assert property (push_go |=> pointers.fp == $past(pointers.fp) - 12'h001) else $error("push step");
  chk_sub_first: assert property (sub_go && instr_word[7:6] == 2'h0 |=>
    pointers.p0 == $past(pointers.p0) - $past(k)) else $error("subtract wrong");
  chk_return_load: assert property (sub_go && instr_word[7:6] == 2'h3 |=> pc_load
    && pc_load_value == $past(return_stack_top) && pointers.fp == $past(pointers.fp) - $past(k)
    && pointers.p0 == $past(pointers.p0) && !instr_ready [*3]) else $error("return wrong");
  chk_off_quiet: assert property (!$past(ext_enabled) |-> !mem_req.rd_en && !mem_req.wr_en && !pc_load)
    else $error("disabled block acted");
  chk_std_legacy: assert property (!ext_enabled && !std_operand.a_bit ##1 !ext_enabled |->
    std_addr == {($past(std_operand.f) <= 8'h5F) ? 4'h0 : 4'hF, $past(std_operand.f)}) else $error("legacy operand");
  chk_std_indexed: assert property (ext_enabled && !std_operand.a_bit && std_operand.f <= 8'h5F ##1 ext_enabled |->
    std_indexed && std_addr == $past(pointers.fp) + {4'h0, $past(std_operand.f)}) else $error("indexed operand");
  cov_push: cover property (push_go);
  cov_return: cover property (sub_go && instr_word[7:6] == 2'h3);
  cov_move_end: cover property (take && move_wait);
endmodule
bind indexed_stack_instruction_exec stack_exec_monitor stack_exec_monitor_inst (.*);
`default_nettype wire

// [stack_exec_pkg.sv]
// Constants, types and helpers shared by the indexed stack instruction block
// Functional notes
// - Move addresses are frame pointer plus 7-bit offsets
// - Move is two words, read then write
// - Move never writes program counter or stack top
// - Indirect register source reads as zero
// - Indirect register destination makes move a no-operation
// - Push writes 8-bit literal at frame pointer
// - Push then decrements frame pointer by one
// - Subtract 6-bit literal from pointer 0..2
// - Subtract-and-return subtracts then loads PC, two cycles
// - Select value 3 means subtract-and-return on frame pointer
// - Extension enable also switches on indexed operand mode
// - Disabled: access bit picks access bank or bank
// - Enabled, access 0, operand <= 5Fh: frame-relative
// - Frame pointer zero gives legacy access mapping
// - Destination select bit keeps its normal meaning
// - Enable bit resets to 0, set by software
package stack_exec_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int WORD_W = 16;
  localparam int PC_W = 21;
  localparam int PHASES = 4;
  // Opcode prefixes
  localparam logic [8:0] OP_MOVE_FIRST = 9'h1D7;
  localparam logic [3:0] OP_MOVE_SECOND = 4'hF;
  localparam logic [7:0] OP_PUSH = 8'hFA;
  localparam logic [7:0] OP_SUB_PTR = 8'hE9;
  localparam logic [1:0] SEL_RETURN = 2'h3;
  localparam logic [1:0] SEL_PTR1 = 2'h1;
  localparam logic [1:0] SEL_PTR0 = 2'h0;
  // Special data addresses
  localparam logic [ADDR_W-1:0] ADDR_PC_LOW = 12'hFF9;
  localparam logic [ADDR_W-1:0] ADDR_TOP_UPPER = 12'hFFF;
  localparam logic [ADDR_W-1:0] ADDR_TOP_HIGH = 12'hFFE;
  localparam logic [ADDR_W-1:0] ADDR_TOP_LOW = 12'hFFD;
  localparam logic [ADDR_W-1:0] IND0_LO = 12'hFEB;
  localparam logic [ADDR_W-1:0] IND0_HI = 12'hFEF;
  localparam logic [ADDR_W-1:0] IND1_LO = 12'hFE3;
  localparam logic [ADDR_W-1:0] IND1_HI = 12'hFE7;
  localparam logic [ADDR_W-1:0] IND2_LO = 12'hFDB;
  localparam logic [ADDR_W-1:0] IND2_HI = 12'hFDF;
  localparam logic [7:0] ACCESS_LIMIT = 8'h5F;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [DATA_W-1:0] ZERO_DATA = 8'h00;
  localparam logic [ADDR_W-1:0] PTR_STEP = 12'h001;
  localparam logic [ADDR_W-1:0] PTR_RESET = 12'h000;
  // Register offsets and fields
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_FRAME = 8'h04;
  localparam logic [7:0] REG_PTR0 = 8'h08;
  localparam logic [7:0] REG_PTR1 = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam int CTRL_EXT_BIT = 0;
  localparam logic CTRL_EXT_RESET = 1'b0;

  typedef enum logic [1:0] {
    ST_FETCH,
    ST_MOVE_DEST,
    ST_RETURN_IDLE
  } state_t;

  typedef enum logic [2:0] {
    OPK_NONE,
    OPK_MOVE,
    OPK_PUSH,
    OPK_SUB,
    OPK_RETURN,
    OPK_NOP
  } opkind_t;

  typedef struct packed {
    logic [ADDR_W-1:0] fp;
    logic [ADDR_W-1:0] p1;
    logic [ADDR_W-1:0] p0;
  } ptr_set_t;

  typedef struct packed {
    logic rd_en;
    logic wr_en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic a_bit;
    logic d_bit;
    logic [7:0] f;
    logic [3:0] bank;
  } operand_t;

  // Frame-relative address, wrapping in the data space
  function automatic logic [ADDR_W-1:0] fp_offset(input logic [ADDR_W-1:0] fp, input logic [7:0] ofs);
    fp_offset = fp + {4'h0, ofs};
  endfunction

  function automatic logic is_indirect(input logic [ADDR_W-1:0] a);
    is_indirect = (a >= IND0_LO && a <= IND0_HI) || (a >= IND1_LO && a <= IND1_HI) ||
                  (a >= IND2_LO && a <= IND2_HI);
  endfunction

  function automatic logic is_protected(input logic [ADDR_W-1:0] a);
    is_protected = (a == ADDR_PC_LOW) || (a == ADDR_TOP_UPPER) || (a == ADDR_TOP_HIGH) ||
                   (a == ADDR_TOP_LOW);
  endfunction
endpackage

// [test_indexed_stack_instruction_exec.sv]
// Self-checking testbench of the indexed stack instruction block
`timescale 1ns/1ps
`default_nettype none
module test_indexed_stack_instruction_exec;
  logic ref_clk, rst, instr_valid, instr_ready, cycle_tick, pc_load, std_dest_is_file, std_indexed, ext_enabled;
  logic psel, penable, pwrite, pready, pslverr, err;
  logic [15:0] instr_word;
  logic [7:0] mem_rdata, paddr;
  logic [20:0] return_stack_top, pc_load_value;
  logic [11:0] std_addr, fpv;
  logic [31:0] pwdata, prdata, rd, r, seed = 32'h4575641A;
  logic [3:0] pstrb;
  stack_exec_pkg::mem_req_t mem_req;
  stack_exec_pkg::operand_t std_operand;
  stack_exec_pkg::ptr_set_t pointers, ep;
  int fails, num_checks, cycles, w0;
  indexed_stack_instruction_exec indexed_stack_instruction_exec_inst (.*);
  data_memory_model data_memory_model_inst (.*);
  // Core clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // Hang guard
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      chk(1'b0, "timeout");
      wrap_up();
    end
  end
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Indirect access windows and move-protected targets
  function automatic logic hot(input logic [11:0] a);
    return (a >= 12'hFDB && a <= 12'hFDF) || (a >= 12'hFE3 && a <= 12'hFE7) || (a >= 12'hFEB && a <= 12'hFEF);
  endfunction
  function automatic logic prot(input logic [11:0] a);
    return a == 12'hFF9 || a >= 12'hFFD;
  endfunction
  task automatic chk(input bit ok, input string msg);
    num_checks++;
    if (!ok) begin
      fails++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  task automatic wrap_up();
    if (fails == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  // Offer a word until a cycle boundary takes it
  task automatic issue(input logic [15:0] w);
    instr_valid <= 1'b1;
    instr_word <= w;
    do @(posedge ref_clk); while (!(cycle_tick === 1'b1 && instr_ready === 1'b1));
    instr_valid <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic std_case(input logic e, input logic a, input logic [7:0] f, input logic [11:0] fp);
    stack_exec_pkg::operand_t o;
    r = rnd();
    o = r[13:0];
    o.a_bit = a;
    o.f = f;
    std_operand <= o;
    repeat (2) @(posedge ref_clk);
    chk(std_addr === (a ? {o.bank, f} : (e && f <= 8'h5F) ? fp + {4'h0, f} : {(f > 8'h5F) ? 4'hF : 4'h0, f}),
      "operand address");
    chk(std_dest_is_file === o.d_bit && std_indexed === (e && !a && f <= 8'h5F), "operand flags");
  endtask
  task automatic move_case(input logic [11:0] fp, input logic [6:0] zs, input logic [6:0] zd);
    logic [11:0] s, t;
    logic [7:0] v;
    s = fp + {5'h00, zs};
    t = fp + {5'h00, zd};
    v = hot(s) ? 8'h00 : data_memory_model_inst.mem[s];
    if (hot(t) || prot(t)) v = data_memory_model_inst.mem[t];
    apb(1'b1, 8'h04, {20'h0, fp});
    issue({9'h1D7, zs});
    issue({4'hF, 5'h15, zd});
    repeat (2) @(posedge ref_clk);
    chk(data_memory_model_inst.mem[t] === v, "move result");
  endtask
  initial begin
    {rst, instr_valid, psel, penable, pwrite, instr_word, paddr, pwdata, return_stack_top, std_operand} = '0;
    rst = 1'b1;
    pstrb = 4'hF;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd === 32'h0 && pointers === '0 && ext_enabled === 1'b0, "reset state");
    // Disabled: instructions ignored, operands literal
    w0 = data_memory_model_inst.writes;
    issue(16'hFA3C);
    repeat (2) @(posedge ref_clk);
    chk(pointers.fp === 12'h000 && data_memory_model_inst.writes == w0, "disabled push");
    for (int i = 0; i < 12; i++) std_case(1'b0, r[8], r[7:0], 12'h000);
    apb(1'b1, 8'h00, 32'h1);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd === 32'h1 && ext_enabled === 1'b1, "enable bit");
    apb(1'b0, 8'h14, 32'h0);
    chk(err === 1'b1 && rd === 32'h0, "unmapped read");
    // Frame-relative operands, limit values and a zero frame
    for (int i = 0; i < 16; i++) begin
      fpv = (i == 3) ? 12'h000 : rnd();
      apb(1'b1, 8'h04, {20'h0, fpv});
      std_case(1'b1, r[9] & (i > 3), (i < 2) ? 8'h5F + i[7:0] : r[7:0], fpv);
    end
    // Push, from a zero frame that wraps
    for (int i = 0; i < 6; i++) begin
      r = rnd();
      fpv = (i == 0) ? 12'h000 : r[31:20];
      apb(1'b1, 8'h04, {20'h0, fpv});
      issue({8'hFA, r[7:0]});
      chk(pointers.fp === fpv - 12'h001, "push pointer");
      @(posedge ref_clk);
      chk(data_memory_model_inst.mem[fpv] === r[7:0], "push data");
    end
    // Every pointer select, the last being the return form
    for (int s = 0; s < 4; s++) begin
      r = rnd();
      apb(1'b1, 8'h08, {20'h0, r[31:20]});
      return_stack_top <= r[20:0];
      ep = pointers;
      issue({8'hE9, s[1:0], r[5:0]});
      if (s == 0) ep.p0 = ep.p0 - {6'h00, r[5:0]};
      else if (s == 1) ep.p1 = ep.p1 - {6'h00, r[5:0]};
      else ep.fp = ep.fp - {6'h00, r[5:0]};
      chk(pointers === ep, "pointer subtract");
      chk(pc_load === (s == 3) && (s < 3 || pc_load_value === r[20:0]) && instr_ready === (s != 3), "return");
    end
    // Plain, indirect source, indirect and protected targets, wrap
    move_case(12'h080, 7'h05, 7'h06);
    move_case(12'hFD0, 7'h1B, 7'h02);
    move_case(12'hFD0, 7'h02, 7'h13);
    move_case(12'hFC0, 7'h02, 7'h39);
    move_case(12'hFC0, 7'h03, 7'h3F);
    move_case(12'hFF0, 7'h20, 7'h7F);
    w0 = data_memory_model_inst.writes;
    ep = pointers;
    issue(16'hF35C);
    repeat (2) @(posedge ref_clk);
    chk(pointers === ep && data_memory_model_inst.writes == w0, "lone second word");
    wrap_up();
  end
endmodule
`default_nettype wire
